/* rcpwm_ctrl.sv */
// remote carrier pwm control: ahb-lite registers, clock divider, counters, output
//
// What this block does
// - debug_clock_keep 1 keeps operating clock in debug mode; 0 withholds it.
// - clock_source_sel picks internal, low-speed crystal, high-speed or external source.
// - divider n divides by 2**n; low-speed up to 1/256, external 1/1 only.
// - unimplemented clock sources cannot be written into clock_source_sel.
// - clock control writes take effect only while module_enable is 0.
// - counter reset bit clears both counters, reads 1 until done, self-clears.
// - counter_run 1 starts, 0 stops both counters; reads back running state.
// - one-shot cycle match clears counter_run automatically.
// - output_invert 1 inverts the pin, 0 passes it straight.
// - compare_buffer_enable switches buffers; keep 0 on first length writes.
// - oneshot_select 1 is one-shot, 0 is repeat mode.
// - software_reset clears counters and flags, reads 1 while busy, self-clears.
// - module_enable gates the operating clock and enables operation.
// - data_counter_value reads live counter, resets 0, cleared by software reset.
// - pin active from count zero until count exceeds active pulse length.
// - data cycle runs from zero until count exceeds data cycle length.
// - length register writes accepted only while module_enable is 1.
// - status shows running bit and two busy flags valid with buffers on.
// - match flags clear on write 1 or software reset; write 0 ignored.
// - pin is carrier AND data signal, then optional inversion.
// - carrier toggles on duty match, again on period match, counter to zero.
// - buffers load on cycle match; busy sets on write, clears on transfer.
// - repeat runs until stopped; one-shot stops at data length match.
//
// Our own choices: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/1ns

module rcpwm_ctrl
	import rcpwm_pkg::*;
#(
	parameter logic [3:0] SRC_IMPLEMENTED = 4'hf
) (
	// clock and reset
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// ahb-lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic      [31:0] hrdata,
	// clock sources, one-cycle tick per source edge
	input  wire logic [3:0]  src_tick,
	input  wire logic        debug_mode,
	// pin
	output logic             modulated_output_pin
);

	// ------------------------------------------------------------
	// decoding helpers
	// ------------------------------------------------------------
	// effective division exponent for a source
	function automatic logic [3:0] eff_div(input logic [1:0] src, input logic [3:0] div);
		logic [3:0] n;
		n = div;
		if (src == RCPWM_SRC_LOW_SPEED_CRYSTAL && div > RCPWM_DIV_LOW_SPEED_MAX) begin
			n = RCPWM_DIV_NONE;
		end
		if (src == RCPWM_SRC_EXTERNAL_CLOCK_INPUT) begin
			n = RCPWM_DIV_NONE;
		end
		return n;
	endfunction

	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		return a == off;
	endfunction

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	rcpwm_clk_cfg_t                clk_cfg;
	rcpwm_ctrl_t                   ctrl;
	logic                          counter_run;
	logic                          counter_reset_pend;
	logic                          software_reset;
	logic [15:0]                   active_pulse_length;
	logic [15:0]                   data_cycle_length;
	logic [15:0]                   ap_buf;
	logic [15:0]                   db_buf;
	logic                          pulse_length_busy;
	logic                          cycle_length_busy;
	logic                          pulse_match_flag;
	logic                          cycle_match_flag;
	logic [15:0]                   data_counter_value;
	logic [7:0]                    carrier_counter;
	logic [7:0]                    carrier_duty_value;
	logic [7:0]                    carrier_period_value;
	logic                          carrier_enable;
	logic [RCPWM_PRESCALE_W-1:0]   prescale;
	logic                          dph_valid;
	logic                          dph_write;
	logic [7:0]                    dph_addr;

	logic                          clk_gate;
	logic                          div_hit;
	logic                          op_tick;
	logic [RCPWM_PRESCALE_W-1:0]   div_mask;
	logic [15:0]                   ap_cmp;
	logic [15:0]                   db_cmp;
	logic                          count_step;
	logic                          ap_match;
	logic                          db_match;
	logic                          data_sig;
	logic                          carrier_sig;
	logic                          wr_clk;
	logic                          wr_ctrl;
	logic                          wr_ap;
	logic                          wr_db;
	logic                          wr_stat;
	logic                          wr_carr;
	logic                          wr_carren;
	logic [15:0]                   wd;

	// ------------------------------------------------------------
	// ahb-lite slave: zero wait states, always okay
	// ------------------------------------------------------------
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dph_valid <= 1'b0;
			dph_write <= 1'b0;
			dph_addr  <= 8'h00;
		end else if (hready) begin
			dph_valid <= hsel && htrans[1];
			dph_write <= hwrite;
			dph_addr  <= haddr[7:0];
		end
	end

	assign wd        = hwdata[15:0];
	assign wr_clk    = dph_valid && dph_write && hit(dph_addr, RCPWM_OFF_CLK);
	assign wr_ctrl   = dph_valid && dph_write && hit(dph_addr, RCPWM_OFF_CTRL);
	assign wr_ap     = dph_valid && dph_write && hit(dph_addr, RCPWM_OFF_APLEN);
	assign wr_db     = dph_valid && dph_write && hit(dph_addr, RCPWM_OFF_DBLEN);
	assign wr_stat   = dph_valid && dph_write && hit(dph_addr, RCPWM_OFF_STAT);
	assign wr_carr   = dph_valid && dph_write && hit(dph_addr, RCPWM_OFF_CARR);
	assign wr_carren = dph_valid && dph_write && hit(dph_addr, RCPWM_OFF_CARREN);

	// read mux over register flops; unmapped reads give zero
	// reserved bits zero
	always_comb begin
		hrdata = 32'h0000_0000;
		if (dph_valid && !dph_write) begin
			if (hit(dph_addr, RCPWM_OFF_CLK)) begin
				hrdata[RCPWM_CLK_KEEP_BIT]                  = clk_cfg.debug_clock_keep;
				hrdata[RCPWM_CLK_DIV_LSB +: 4]              = clk_cfg.clock_divider_sel;
				hrdata[RCPWM_CLK_SRC_LSB +: 2]              = clk_cfg.clock_source_sel;
			end
			if (hit(dph_addr, RCPWM_OFF_CTRL)) begin
				hrdata[RCPWM_CTL_PRE_BIT] = counter_reset_pend;
				hrdata[RCPWM_CTL_RUN_BIT] = counter_run;
				hrdata[RCPWM_CTL_INV_BIT] = ctrl.output_invert;
				hrdata[RCPWM_CTL_BUF_BIT] = ctrl.compare_buffer_enable;
				hrdata[RCPWM_CTL_ONE_BIT] = ctrl.oneshot_select;
				hrdata[RCPWM_CTL_SWR_BIT] = software_reset;
				hrdata[RCPWM_CTL_EN_BIT]  = ctrl.module_enable;
			end
			if (hit(dph_addr, RCPWM_OFF_DCNT)) begin
				hrdata[15:0] = data_counter_value;
			end
			if (hit(dph_addr, RCPWM_OFF_APLEN)) begin
				hrdata[15:0] = active_pulse_length;
			end
			if (hit(dph_addr, RCPWM_OFF_DBLEN)) begin
				hrdata[15:0] = data_cycle_length;
			end
			if (hit(dph_addr, RCPWM_OFF_STAT)) begin
				hrdata[RCPWM_ST_RUN_BIT]   = counter_run;
				hrdata[RCPWM_ST_DBBSY_BIT] = cycle_length_busy;
				hrdata[RCPWM_ST_APBSY_BIT] = pulse_length_busy;
				hrdata[RCPWM_ST_CYCLE_MATCH_FLAG_BIT]  = cycle_match_flag;
				hrdata[RCPWM_ST_PULSE_MATCH_FLAG_BIT]  = pulse_match_flag;
			end
			if (hit(dph_addr, RCPWM_OFF_CARR)) begin
				hrdata[RCPWM_CAR_DTY_LSB +: 8] = carrier_duty_value;
				hrdata[RCPWM_CAR_PER_LSB +: 8] = carrier_period_value;
			end
			if (hit(dph_addr, RCPWM_OFF_CARREN)) begin
				hrdata[0] = carrier_enable;
			end
		end
	end

	// ------------------------------------------------------------
	// clock control register
	// ------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			clk_cfg <= RCPWM_RST_CLK_CFG;
		end else if (wr_clk && !ctrl.module_enable) begin
			clk_cfg.debug_clock_keep  <= wd[RCPWM_CLK_KEEP_BIT];
			clk_cfg.clock_divider_sel <= wd[RCPWM_CLK_DIV_LSB +: 4];
			if (SRC_IMPLEMENTED[wd[RCPWM_CLK_SRC_LSB +: 2]]) begin
				clk_cfg.clock_source_sel <= wd[RCPWM_CLK_SRC_LSB +: 2];
			end
		end
	end

	// ------------------------------------------------------------
	// operating clock enable
	// ------------------------------------------------------------
	// debug clock gate
	assign clk_gate = ctrl.module_enable && !software_reset &&
		!(debug_mode && !clk_cfg.debug_clock_keep) &&
		src_tick[clk_cfg.clock_source_sel];

	assign div_mask = RCPWM_PRESCALE_W'((1 << eff_div(clk_cfg.clock_source_sel,
		clk_cfg.clock_divider_sel)) - 1);
	assign div_hit  = &(prescale | ~div_mask);
	assign op_tick  = clk_gate && div_hit;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			prescale <= '0;
		end else if (!ctrl.module_enable) begin
			prescale <= '0;
		end else if (clk_gate) begin
			prescale <= prescale + 1'b1;
		end
	end

	// ------------------------------------------------------------
	// counter control register
	// ------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl <= RCPWM_RST_CTRL;
		end else if (wr_ctrl) begin
			ctrl.output_invert         <= wd[RCPWM_CTL_INV_BIT];
			ctrl.compare_buffer_enable <= wd[RCPWM_CTL_BUF_BIT];
			ctrl.oneshot_select        <= wd[RCPWM_CTL_ONE_BIT];
			ctrl.module_enable         <= wd[RCPWM_CTL_EN_BIT];
		end
	end

	// software reset lasts one cycle then self-clears
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			software_reset <= 1'b0;
		end else begin
			software_reset <= wr_ctrl && wd[RCPWM_CTL_SWR_BIT];
		end
	end

	// counter reset request, cleared on completion or software reset
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			counter_reset_pend <= 1'b0;
		end else if (software_reset) begin
			counter_reset_pend <= 1'b0;
		end else if (wr_ctrl && wd[RCPWM_CTL_PRE_BIT] && ctrl.module_enable) begin
			counter_reset_pend <= 1'b1;
		end else if (op_tick) begin
			counter_reset_pend <= 1'b0;
		end
	end

	// run bit: start, stop, reads running
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			counter_run <= 1'b0;
		end else if (software_reset) begin
			counter_run <= 1'b0;
		end else if (wr_ctrl && ctrl.module_enable) begin
			counter_run <= wd[RCPWM_CTL_RUN_BIT];
		end else if (db_match && ctrl.oneshot_select) begin
			counter_run <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// length registers and compare buffers
	// ------------------------------------------------------------
	// writes only while enabled
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			active_pulse_length <= RCPWM_RST_LEN;
		end else if (wr_ap && ctrl.module_enable && !pulse_length_busy) begin
			active_pulse_length <= wd;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			data_cycle_length <= RCPWM_RST_LEN;
		end else if (wr_db && ctrl.module_enable && !cycle_length_busy) begin
			data_cycle_length <= wd;
		end
	end

	// buffers track registers when off, load on cycle match when on
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ap_buf <= RCPWM_RST_LEN;
			db_buf <= RCPWM_RST_LEN;
		end else if (!ctrl.compare_buffer_enable || db_match) begin
			ap_buf <= active_pulse_length;
			db_buf <= data_cycle_length;
		end
	end

	// busy set on write, cleared on transfer; a write landing in the transfer cycle wins
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pulse_length_busy <= 1'b0;
			cycle_length_busy <= 1'b0;
		end else if (!ctrl.compare_buffer_enable) begin
			pulse_length_busy <= 1'b0;
			cycle_length_busy <= 1'b0;
		end else begin
			if (wr_ap && ctrl.module_enable && !pulse_length_busy) begin
				pulse_length_busy <= 1'b1;
			end else if (db_match) begin
				pulse_length_busy <= 1'b0;
			end
			if (wr_db && ctrl.module_enable && !cycle_length_busy) begin
				cycle_length_busy <= 1'b1;
			end else if (db_match) begin
				cycle_length_busy <= 1'b0;
			end
		end
	end

	assign ap_cmp = ctrl.compare_buffer_enable ? ap_buf : active_pulse_length;
	assign db_cmp = ctrl.compare_buffer_enable ? db_buf : data_cycle_length;

	// ------------------------------------------------------------
	// data and carrier counters
	// ------------------------------------------------------------
	assign count_step = op_tick && counter_run && !counter_reset_pend;
	assign ap_match   = count_step && (data_counter_value == ap_cmp);
	assign db_match   = count_step && (data_counter_value == db_cmp);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			data_counter_value <= RCPWM_RST_DCNT;
		end else if (software_reset) begin
			data_counter_value <= RCPWM_RST_DCNT;
		end else if (op_tick && counter_reset_pend) begin
			data_counter_value <= RCPWM_RST_DCNT;
		end else if (db_match) begin
			data_counter_value <= RCPWM_RST_DCNT;
		end else if (count_step) begin
			data_counter_value <= data_counter_value + 16'h0001;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			carrier_counter <= RCPWM_RST_CCNT;
		end else if (software_reset || (op_tick && counter_reset_pend)) begin
			carrier_counter <= RCPWM_RST_CCNT;
		end else if (count_step) begin
			if (carrier_counter == carrier_period_value) begin
				carrier_counter <= RCPWM_RST_CCNT;
			end else begin
				carrier_counter <= carrier_counter + 8'h01;
			end
		end
	end

	// ------------------------------------------------------------
	// match flags, write 1 to clear, set wins
	// ------------------------------------------------------------
	// flag clear
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pulse_match_flag <= 1'b0;
			cycle_match_flag <= 1'b0;
		end else if (software_reset) begin
			pulse_match_flag <= 1'b0;
			cycle_match_flag <= 1'b0;
		end else begin
			if (ap_match) begin
				pulse_match_flag <= 1'b1;
			end else if (wr_stat && wd[RCPWM_ST_PULSE_MATCH_FLAG_BIT]) begin
				pulse_match_flag <= 1'b0;
			end
			if (db_match) begin
				cycle_match_flag <= 1'b1;
			end else if (wr_stat && wd[RCPWM_ST_CYCLE_MATCH_FLAG_BIT]) begin
				cycle_match_flag <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// carrier registers
	// ------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			carrier_duty_value   <= RCPWM_RST_CAR;
			carrier_period_value <= RCPWM_RST_CAR;
			carrier_enable       <= 1'b0;
		end else begin
			if (wr_carr) begin
				carrier_duty_value   <= wd[RCPWM_CAR_DTY_LSB +: 8];
				carrier_period_value <= wd[RCPWM_CAR_PER_LSB +: 8];
			end
			if (wr_carren) begin
				carrier_enable <= wd[0];
			end
		end
	end

	// ------------------------------------------------------------
	// output pin
	// ------------------------------------------------------------
	// active from zero through pulse length
	assign data_sig    = counter_run && (data_counter_value <= ap_cmp);
	// high from zero through duty value
	assign carrier_sig = !carrier_enable || (carrier_counter <= carrier_duty_value);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			modulated_output_pin <= 1'b0;
		end else begin
			modulated_output_pin <= (data_sig && carrier_sig) ^ ctrl.output_invert;
		end
	end

endmodule

/* rcpwm_ctrl_props.sv */
// port checker for the remote carrier pwm control block
`timescale 1ns/1ns
module rcpwm_ctrl_props
	import rcpwm_pkg::*;
(
	// clock and reset
	input wire logic        hclk,
	input wire logic        hresetn,
	// bus
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic [2:0]  hsize,
	input wire logic [31:0] hwdata,
	input wire logic        hready,
	input wire logic        hreadyout,
	input wire logic        hresp,
	input wire logic [31:0] hrdata,
	// sources and pin
	input wire logic [3:0]  src_tick,
	input wire logic        debug_mode,
	input wire logic        modulated_output_pin
);
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// ----------------------------------------
	// read address phase
	// ----------------------------------------
	sequence s_rd;
		hsel && hready && htrans[1] && !hwrite;
	endsequence
	sequence s_ctrl_idle;
		s_rd ##0 haddr[7:0] == RCPWM_OFF_CTRL ##1 !hrdata[8];
	endsequence
	a_ready_const: assert property (hreadyout)
		else $error("hreadyout low");
	a_resp_okay: assert property (hresp == 1'b0)
		else $error("hresp not okay");
	a_rd_quiet: assert property (!(hsel && hready && htrans[1] && !hwrite) |=> hrdata == 32'h0)
		else $error("hrdata outside read");
	a_upper_zero: assert property (s_rd |=> hrdata[31:16] == 16'h0)
		else $error("upper read bits set");
	a_unmapped_zero: assert property (s_rd ##0 haddr[7:0] >= 8'h20 |=> hrdata == 32'h0)
		else $error("unmapped read not zero");
	a_clk_resv: assert property (s_rd ##0 haddr[7:0] == RCPWM_OFF_CLK
		|=> hrdata[15:9] == 7'h0 && hrdata[3:2] == 2'h0)
		else $error("clock reserved bits set");
	a_ctrl_resv: assert property (s_rd ##0 haddr[7:0] == RCPWM_OFF_CTRL
		|=> hrdata[15:10] == 6'h0 && hrdata[7:5] == 3'h0)
		else $error("control reserved bits set");
	a_stat_resv: assert property (s_rd ##0 haddr[7:0] == RCPWM_OFF_STAT
		|=> hrdata[15:11] == 5'h0 && hrdata[7:2] == 6'h0)
		else $error("status reserved bits set");
	a_idle_pin: assert property (s_ctrl_idle |=> modulated_output_pin == $past(hrdata[4]))
		else $error("idle pin level wrong");
endmodule

bind rcpwm_ctrl rcpwm_ctrl_props u_props (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
	.hsize, .hwdata, .hready, .hreadyout, .hresp, .hrdata, .src_tick, .debug_mode,
	.modulated_output_pin);

/* rcpwm_ctrl_test.sv */
// testbench of the remote carrier pwm control block
`timescale 1ns/1ns
module rcpwm_ctrl_test;
	import rcpwm_pkg::*;
	logic        hclk = 1'b0, hresetn = 1'b0, hwrite = 1'b0, debug_mode = 1'b0, clr = 1'b1;
	logic        hreadyout, hresp, pin;
	logic [1:0]  htrans = 2'h0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, q;
	logic [3:0]  src_tick = 4'hf;
	logic [15:0] lit;
	int          err_total = 0, tests_run = 0;
	always #5 hclk = ~hclk;
	rcpwm_ctrl dut (.hclk, .hresetn, .hsel(1'b1), .haddr, .htrans, .hwrite, .hsize(3'h2),
		.hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .src_tick, .debug_mode,
		.modulated_output_pin(pin));
	rcpwm_led_model led (.hclk, .pin, .clr, .lit);
	task automatic wrap_up;
		$display("errors %0d checks %0d", err_total, tests_run);
		if (err_total == 0 && tests_run > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] v);
		tests_run++;
		if (v !== e) begin
			err_total++;
			$display("wrong value %s expected %h seen %h", nm, e, v);
		end
	endtask
	task automatic ready;
		int n;
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (hreadyout !== 1'b1 && n < 50);
		if (hreadyout !== 1'b1) begin
			err_total++;
			wrap_up;
		end
	endtask
	task automatic xfer(input logic [7:0] a, input logic w, input logic [15:0] d);
		@(posedge hclk);
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= w;
		ready;
		htrans <= 2'h0;
		hwdata <= {16'h0, d};
		ready;
		q = hrdata;
	endtask
	task automatic rd(input logic [7:0] a, input logic [15:0] e, input string nm);
		xfer(a, 1'b0, 16'h0);
		chk(nm, {16'h0, e}, q);
	endtask
	task automatic wait_idle;
		for (int i = 0; i < 40; i++) begin
			xfer(RCPWM_OFF_CTRL, 1'b0, 16'h0);
			if (q[8] === 1'b0)
				return;
		end
		err_total++;
		wrap_up;
	endtask
	initial begin
		repeat (5) @(posedge hclk);
		hresetn <= 1'b1;
		clr <= 1'b0;
		for (int a = 0; a < 24; a += 4)
			rd(a[7:0], 16'h0, "reset value");
		rd(8'h40, 16'h0, "unmapped");
		xfer(RCPWM_OFF_APLEN, 1'b1, 16'h5);
		rd(RCPWM_OFF_APLEN, 16'h0, "length while off");
		xfer(RCPWM_OFF_CLK, 1'b1, 16'hffff);
		rd(RCPWM_OFF_CLK, 16'h01f3, "clock");
		xfer(RCPWM_OFF_CTRL, 1'b1, 16'h0001);
		xfer(RCPWM_OFF_CLK, 1'b1, 16'h0000);
		rd(RCPWM_OFF_CLK, 16'h01f3, "clock locked");
		xfer(RCPWM_OFF_APLEN, 1'b1, 16'h2);
		xfer(RCPWM_OFF_DBLEN, 1'b1, 16'h5);
		rd(RCPWM_OFF_DBLEN, 16'h5, "cycle length");
		debug_mode <= 1'b1;
		xfer(RCPWM_OFF_CTRL, 1'b1, 16'h0105);
		wait_idle;
		chk("lit cycles", 32'h3, {16'h0, lit});
		rd(RCPWM_OFF_STAT, 16'h0003, "flags");
		rd(RCPWM_OFF_DCNT, 16'h0, "count wrapped");
		xfer(RCPWM_OFF_STAT, 1'b1, 16'h0);
		rd(RCPWM_OFF_STAT, 16'h0003, "flags kept");
		xfer(RCPWM_OFF_STAT, 1'b1, 16'h3);
		rd(RCPWM_OFF_STAT, 16'h0, "flags cleared");
		xfer(RCPWM_OFF_CTRL, 1'b1, 16'h0003);
		debug_mode <= 1'b0;
		xfer(RCPWM_OFF_CTRL, 1'b1, 16'h0101);
		repeat (13) @(posedge hclk);
		rd(RCPWM_OFF_STAT, 16'h0403, "running");
		xfer(RCPWM_OFF_CTRL, 1'b1, 16'h0001);
		rd(RCPWM_OFF_CTRL, 16'h0001, "stopped");
		rd(RCPWM_OFF_DCNT, 16'h1, "stopped count");
		xfer(RCPWM_OFF_CTRL, 1'b1, 16'h0201);
		rd(RCPWM_OFF_DCNT, 16'h0, "counter reset");
		rd(RCPWM_OFF_CTRL, 16'h0001, "reset done");
		xfer(RCPWM_OFF_CTRL, 1'b1, 16'h0003);
		rd(RCPWM_OFF_STAT, 16'h0, "soft reset");
		rd(RCPWM_OFF_CTRL, 16'h0001, "soft reset done");
		xfer(RCPWM_OFF_CTRL, 1'b1, 16'h0011);
		repeat (2) @(posedge hclk);
		chk("inverted pin", 32'h1, {31'h0, pin});
		xfer(RCPWM_OFF_CTRL, 1'b1, 16'h0000);
		xfer(RCPWM_OFF_CLK, 1'b1, 16'h0000);
		rd(RCPWM_OFF_CLK, 16'h0, "clock open");
		// internal source only, divide by 4, clock withheld in debug
		src_tick <= 4'h1;
		xfer(RCPWM_OFF_CLK, 1'b1, 16'h0020);
		xfer(RCPWM_OFF_CTRL, 1'b1, 16'h0003);
		xfer(RCPWM_OFF_CTRL, 1'b1, 16'h0101);
		rd(RCPWM_OFF_DCNT, 16'h1, "divided count");
		rd(RCPWM_OFF_DCNT, 16'h1, "divided hold");
		debug_mode <= 1'b1;
		repeat (8) @(posedge hclk);
		rd(RCPWM_OFF_DCNT, 16'h2, "debug withheld");
		wrap_up;
	end
	initial begin
		repeat (20000) @(posedge hclk);
		err_total++;
		wrap_up;
	end
endmodule

/* rcpwm_led_model.sv */
// lamp drive model: counts lit cycles on the modulated pin
`timescale 1ns/1ns
module rcpwm_led_model (
	// clock
	input wire logic        hclk,
	// pin and count
	input wire logic        pin,
	input wire logic        clr,
	output logic     [15:0] lit
);
	always_ff @(posedge hclk) begin
		if (clr)
			lit <= 16'h0;
		else if (pin)
			lit <= lit + 16'h1;
	end
endmodule

/* rcpwm_pkg.sv */
// constants and types of the remote carrier pwm control block
package rcpwm_pkg;

	// ------------------------------------------------------------
	// register byte offsets
	// ------------------------------------------------------------
	localparam logic [7:0] RCPWM_OFF_CLK    = 8'h00;
	localparam logic [7:0] RCPWM_OFF_CTRL   = 8'h04;
	localparam logic [7:0] RCPWM_OFF_DCNT   = 8'h08;
	localparam logic [7:0] RCPWM_OFF_APLEN  = 8'h0c;
	localparam logic [7:0] RCPWM_OFF_DBLEN  = 8'h10;
	localparam logic [7:0] RCPWM_OFF_STAT   = 8'h14;
	localparam logic [7:0] RCPWM_OFF_CARR   = 8'h18;
	localparam logic [7:0] RCPWM_OFF_CARREN = 8'h1c;

	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int RCPWM_CLK_SRC_LSB  = 0;
	localparam int RCPWM_CLK_DIV_LSB  = 4;
	localparam int RCPWM_CLK_KEEP_BIT = 8;
	localparam int RCPWM_CTL_EN_BIT   = 0;
	localparam int RCPWM_CTL_SWR_BIT  = 1;
	localparam int RCPWM_CTL_ONE_BIT  = 2;
	localparam int RCPWM_CTL_BUF_BIT  = 3;
	localparam int RCPWM_CTL_INV_BIT  = 4;
	localparam int RCPWM_CTL_RUN_BIT  = 8;
	localparam int RCPWM_CTL_PRE_BIT  = 9;
	localparam int RCPWM_ST_PULSE_MATCH_FLAG_BIT  = 0;
	localparam int RCPWM_ST_CYCLE_MATCH_FLAG_BIT  = 1;
	localparam int RCPWM_ST_APBSY_BIT = 8;
	localparam int RCPWM_ST_DBBSY_BIT = 9;
	localparam int RCPWM_ST_RUN_BIT   = 10;
	localparam int RCPWM_CAR_PER_LSB  = 0;
	localparam int RCPWM_CAR_DTY_LSB  = 8;

	// ------------------------------------------------------------
	// clock sources and divider limits
	// ------------------------------------------------------------
	localparam logic [1:0] RCPWM_SRC_INTERNAL_OSCILLATOR   = 2'h0;
	localparam logic [1:0] RCPWM_SRC_LOW_SPEED_CRYSTAL     = 2'h1;
	localparam logic [1:0] RCPWM_SRC_HIGH_SPEED_OSCILLATOR = 2'h2;
	localparam logic [1:0] RCPWM_SRC_EXTERNAL_CLOCK_INPUT  = 2'h3;
	localparam logic [3:0] RCPWM_DIV_LOW_SPEED_MAX         = 4'h8;
	localparam logic [3:0] RCPWM_DIV_NONE                  = 4'h0;
	localparam int         RCPWM_PRESCALE_W                = 15;

	// ------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------
	localparam logic [15:0] RCPWM_RST_LEN  = 16'h0000;
	localparam logic [15:0] RCPWM_RST_DCNT = 16'h0000;
	localparam logic [7:0]  RCPWM_RST_CCNT = 8'h00;
	localparam logic [7:0]  RCPWM_RST_CAR  = 8'h00;

	// ------------------------------------------------------------
	// grouped configuration
	// ------------------------------------------------------------
	typedef struct packed {
		logic       debug_clock_keep;
		logic [3:0] clock_divider_sel;
		logic [1:0] clock_source_sel;
	} rcpwm_clk_cfg_t;

	typedef struct packed {
		logic output_invert;
		logic compare_buffer_enable;
		logic oneshot_select;
		logic module_enable;
	} rcpwm_ctrl_t;

	localparam rcpwm_clk_cfg_t RCPWM_RST_CLK_CFG = '0;
	localparam rcpwm_ctrl_t    RCPWM_RST_CTRL    = '0;

endpackage
